/* File: core/tdsp_params.svh */
`ifndef TDSP_PARAMS_SVH
`define TDSP_PARAMS_SVH

// =============================================================
// Defaults
`define TDSP_NMAX_DEF      4
`define TDSP_SOFTBITS_DEF  3
`define TDSP_PULSE_GAP_DEF 2
`define TDSP_READY_LAT     1
`endif

/* File: core/tdsp_pkg.sv */
package tdsp_pkg;
	typedef enum logic [1:0] {
		TDSP_ARCH_PARALLEL = 2'h0,
		TDSP_ARCH_HYBRID   = 2'h1
	} tdsp_arch_t;
	typedef enum logic [1:0] {
		TDSP_SRC_IDLE = 2'h0,
		TDSP_SRC_SEND = 2'h1
	} tdsp_src_state_t;
endpackage

/* File: core/tdsp_link_if.sv */
`timescale 1ns/1ps
`include "tdsp_params.svh"
interface tdsp_link_if #(
	parameter int NSYM     = `TDSP_NMAX_DEF,
	parameter int SOFTBITS = `TDSP_SOFTBITS_DEF
) ();
	logic                       ready;
	logic                       valid;
	logic [NSYM*SOFTBITS-1:0]   rx_soft_symbols;
	logic [NSYM-1:0]            erasure;
	logic                       sop;
	logic                       eop;

	modport decoder (output ready, input valid, rx_soft_symbols, erasure,
		sop, eop);
	modport producer (input ready, output valid, rx_soft_symbols, erasure,
		sop, eop);
endinterface

/* File: core/tdsp_sink_port.sv */
`timescale 1ns/1ps
`include "tdsp_params.svh"
module tdsp_sink_port
	import tdsp_pkg::*;
#(
	parameter int         NSYM      = `TDSP_NMAX_DEF,
	parameter int         SOFTBITS  = `TDSP_SOFTBITS_DEF,
	parameter tdsp_arch_t ARCH      = TDSP_ARCH_HYBRID,
	parameter int         PULSE_GAP = `TDSP_PULSE_GAP_DEF
) (
	// Clock and reset.
	input  wire logic                      clk_sys,
	input  wire logic                      sys_rst,
	// Link towards the producer.
	tdsp_link_if.decoder                   link,
	// User side: datapath hold-off and accepted words.
	input  wire logic                      dp_busy,
	output logic                           word_vld_q,
	output logic [NSYM*SOFTBITS-1:0]       word_sym_q,
	output logic [NSYM-1:0]                word_eras_q,
	output logic                           word_sop_q,
	output logic                           word_eop_q,
	output logic                           hard_mode_q
);
	// =============================================================
	// Parameter checks
	localparam int GAP_W = 5;

	// The gap counter is five bits wide, so longer gaps are refused here
	// rather than silently wrapped into a shorter gap.
	initial begin
		if (NSYM < 1) begin
			$error("tdsp_sink_port: NSYM must be at least one.");
		end
		if (SOFTBITS < 1) begin
			$error("tdsp_sink_port: SOFTBITS must be at least one.");
		end
		if (SOFTBITS > 16) begin
			$error("tdsp_sink_port: SOFTBITS must not exceed sixteen.");
		end
		if (PULSE_GAP < 1) begin
			$error("tdsp_sink_port: PULSE_GAP must be at least one.");
		end
		if (PULSE_GAP > 32) begin
			$error("tdsp_sink_port: PULSE_GAP must not exceed 32.");
		end
		if (ARCH != TDSP_ARCH_PARALLEL && ARCH != TDSP_ARCH_HYBRID) begin
			$error("tdsp_sink_port: unknown architecture.");
		end
	end

	// =============================================================
	// Ready generation
	logic             rdy_q;
	logic             rdy_d;
	logic             rdy_prev_q;
	logic [GAP_W-1:0] gap_q;
	logic [GAP_W-1:0] gap_d;
	logic             hybrid;

	assign hybrid     = (ARCH == TDSP_ARCH_HYBRID);
	assign link.ready = rdy_q;

	// Hybrid ready is a lone pulse followed by PULSE_GAP idle cycles, so
	// the producer always sees ready fall between two offers.
	always_comb begin
		rdy_d = rdy_q;
		gap_d = gap_q;
		if (hybrid) begin
			if (rdy_q) begin
				rdy_d = 1'b0;
				gap_d = GAP_W'(PULSE_GAP - 1);
			end else if (gap_q != '0) begin
				gap_d = gap_q - GAP_W'(1);
			end else begin
				rdy_d = ~dp_busy;
			end
		end else begin
			// Parallel ready follows the hold-off one cycle late.
			rdy_d = ~dp_busy;
		end
	end

	// Ready is low in reset and may first rise at the first edge after
	// the release.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rdy_q <= 1'b0;
		end else begin
			rdy_q <= rdy_d;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			gap_q <= '0;
		end else begin
			gap_q <= gap_d;
		end
	end

	// The registered copy of ready qualifies valid one cycle later. It is
	// kept apart from the counter so the qualifier never depends on the
	// gap length.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rdy_prev_q <= 1'b0;
		end else begin
			rdy_prev_q <= rdy_q;
		end
	end

	// =============================================================
	// Word capture
	logic take;

	assign take = link.valid && rdy_prev_q;

	// One pulse per accepted word; a valid without the qualifier of the
	// previous cycle leaves no trace.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			word_vld_q <= 1'b0;
		end else begin
			word_vld_q <= take;
		end
	end

	// The fields hold their last accepted value while idle, so nothing
	// downstream sees the link wander while valid is low.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			word_sym_q <= '0;
		end else if (take) begin
			word_sym_q <= link.rx_soft_symbols;
		end
	end

	// Erasure flag k stays paired with symbol k of the same word.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			word_eras_q <= '0;
		end else if (take) begin
			word_eras_q <= link.erasure;
		end
	end

	// Block markers are passed on as given; checking their placement is
	// left to the block logic behind this port.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			word_sop_q <= 1'b0;
		end else if (take) begin
			word_sop_q <= link.sop;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			word_eop_q <= 1'b0;
		end else if (take) begin
			word_eop_q <= link.eop;
		end
	end

	// =============================================================
	// Decision mode
	logic hard_d;

	// A single soft bit leaves only the sign, so the datapath runs hard
	// decisions but still honours the erasure flags of each word.
	assign hard_d = (SOFTBITS == 1);

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			hard_mode_q <= 1'b0;
		end else begin
			hard_mode_q <= hard_d;
		end
	end
endmodule

/* File: core/tdsp_producer.sv */
`timescale 1ns/1ps
`include "tdsp_params.svh"
module tdsp_producer
	import tdsp_pkg::*;
#(
	parameter int NSYM     = `TDSP_NMAX_DEF,
	parameter int SOFTBITS = `TDSP_SOFTBITS_DEF
) (
	// Clock and reset.
	input  wire logic                      clk_sys,
	input  wire logic                      sys_rst,
	// User side word offer.
	input  wire logic                      usr_vld,
	input  wire logic [NSYM*SOFTBITS-1:0]  usr_sym,
	input  wire logic [NSYM-1:0]           usr_eras,
	input  wire logic                      usr_sop,
	input  wire logic                      usr_eop,
	output logic                           usr_take_q,
	// Link towards the decoder.
	tdsp_link_if.producer                  link
);
	initial begin
		if (NSYM < 1 || SOFTBITS < 1 || SOFTBITS > 16)
			$error("tdsp_producer: unsupported parameters.");
	end

	// =============================================================
	// Link drive
	logic                     val_q;
	logic [NSYM*SOFTBITS-1:0] sym_q;
	logic [NSYM-1:0]          eras_q;
	logic                     sop_q;
	logic                     eop_q;

	assign link.valid           = val_q;
	assign link.rx_soft_symbols = sym_q;
	assign link.erasure         = eras_q;
	assign link.sop             = sop_q;
	assign link.eop             = eop_q;

	// The user must present sop/eop on first/last word of a block.
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			val_q      <= 1'b0;
			sym_q      <= '0;
			eras_q     <= '0;
			sop_q      <= 1'b0;
			eop_q      <= 1'b0;
			usr_take_q <= 1'b0;
		end else begin
			usr_take_q <= link.ready && usr_vld;
			// Without ready the link registers hold; no data waits for next pulse.
			if (link.ready) begin
				val_q  <= usr_vld;
				sym_q  <= usr_sym;
				eras_q <= usr_eras;
				sop_q  <= usr_sop;
				eop_q  <= usr_eop;
			end
		end
	end
endmodule

/* File: bench/tdsp_link_chk.sv */
`timescale 1ns/1ps
`include "tdsp_params.svh"
module tdsp_link_chk #(
	parameter int NSYM     = `TDSP_NMAX_DEF,
	parameter int SOFTBITS = `TDSP_SOFTBITS_DEF
) (
	// Clock and reset.
	input wire logic                     clk_sys,
	input wire logic                     sys_rst,
	// Link signals.
	input wire logic                     ready,
	input wire logic                     valid,
	input wire logic [NSYM*SOFTBITS-1:0] rx_soft_symbols,
	input wire logic [NSYM-1:0]          erasure,
	input wire logic        sop,
	input wire logic        eop
);
	// =============================================
	// Properties
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	property p_pulse; ready |=> !ready; endproperty
	a_pulse: assert property (p_pulse) else $error("ready held");
	property p_gap; ready |=> !ready [*2]; endproperty
	a_gap: assert property (p_gap) else $error("ready gap short");
	property p_rise; $rose(ready) |-> $past(!ready, 2); endproperty
	a_rise: assert property (p_rise) else $error("ready early");
	property p_hold; !$past(ready) |-> $stable(valid); endproperty
	a_hold: assert property (p_hold) else $error("valid moved");
	property p_hdat; !$past(ready) |-> $stable(rx_soft_symbols); endproperty
	a_hdat: assert property (p_hdat) else $error("data moved");
	property p_hmrk; !$past(ready) |-> $stable({erasure, sop, eop}); endproperty
	a_hmrk: assert property (p_hmrk) else $error("flags moved");
	property p_vrise; $rose(valid) |-> $past(ready); endproperty
	a_vrise: assert property (p_vrise) else $error("valid early");
	property p_vfall; $fell(valid) |-> $past(ready); endproperty
	a_vfall: assert property (p_vfall) else $error("valid dropped");
	// Transfers, block starts and block ends must all be seen.
	c_xfer: cover property ($past(ready) && valid);
	c_sop: cover property (valid && sop);
	c_eop: cover property (valid && eop);
endmodule

/* File: bench/tdsp_sink_port_bench.sv */
`timescale 1ns/1ps
module tdsp_sink_port_bench;
	logic        clk_sys = 0, sys_rst = 1, dp_busy = 0;
	logic        usr_vld = 0, usr_sop = 0, usr_eop = 0;
	logic [11:0] usr_sym = 0, word_sym_q;
	logic [3:0]  usr_eras = 0, word_eras_q;
	logic        usr_take_q, word_vld_q, word_sop_q, word_eop_q, hard_mode_q;
	logic [17:0] exp_q[$];
	int          n_mismatch = 0, comparisons = 0, n_words = 0;
	always #12.5 clk_sys = ~clk_sys;
	tdsp_link_if link ();
	tdsp_sink_port tdsp_sink_port_inst (.clk_sys, .sys_rst, .link, .dp_busy,
		.word_vld_q, .word_sym_q, .word_eras_q, .word_sop_q, .word_eop_q,
		.hard_mode_q);
	tdsp_producer tdsp_producer_inst (.clk_sys, .sys_rst, .usr_vld, .usr_sym,
		.usr_eras, .usr_sop, .usr_eop, .usr_take_q, .link);
	tdsp_link_chk tdsp_link_chk_inst (.clk_sys, .sys_rst, .ready(link.ready),
		.valid(link.valid), .rx_soft_symbols(link.rx_soft_symbols),
		.erasure(link.erasure), .sop(link.sop), .eop(link.eop));
	// =============================================
	// Tasks
	task chk(string s, logic [17:0] e, logic [17:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask
	// The offer stays up until the producer reports it loaded.
	task send(logic [17:0] w);
		bit got;
		got = 0;
		@(posedge clk_sys) #1;
		{usr_sym, usr_eras, usr_sop, usr_eop} = w;
		usr_vld = 1;
		exp_q.push_back(w);
		repeat (20) begin
			@(posedge clk_sys) #1;
			if (usr_take_q === 1'b1) begin
				got = 1;
				break;
			end
		end
		if (!got) chk("take", 1, 0);
	endtask
	task stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(negedge clk_sys) if (word_vld_q === 1'b1) begin
		n_words++;
		if (exp_q.size() == 0) chk("stray", 0, 1);
		else chk("word", exp_q.pop_front(), {word_sym_q, word_eras_q,
			word_sop_q, word_eop_q});
	end
	// =============================================
	// Tests
	initial begin
		repeat (3) @(posedge clk_sys);
		#1 sys_rst = 0;
		for (int i = 0; i < 6; i++)
			send({12'(i * 'h2d5 + 1), 4'(1 << i), i == 0, i == 5});
		#1 usr_vld = 0;
		chk("hard", 0, hard_mode_q);
		dp_busy = 1;
		repeat (2) @(posedge clk_sys);
		repeat (6) @(negedge clk_sys) chk("rdy", 0, link.ready);
		@(posedge clk_sys) #1 dp_busy = 0;
		usr_sym = 12'hfff;
		usr_eras = 4'hf;
		repeat (9) @(posedge clk_sys);
		chk("idle", 18'(6), 18'(n_words));
		send(18'h2a5c6);
		#1 usr_vld = 0;
		repeat (3) @(posedge clk_sys);
		#1 sys_rst = 1;
		@(posedge clk_sys) chk("rst", 0, {link.ready, word_vld_q});
		exp_q.delete();
		#1 sys_rst = 0;
		send(18'h15a39);
		#1 usr_vld = 0;
		repeat (8) @(posedge clk_sys);
		chk("left", 0, 18'(exp_q.size()));
		stop_test;
	end
	initial begin
		#20us n_mismatch++;
		stop_test;
	end
endmodule
